// >>> rtl/hapd_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module hapd_addr_decode
  import hapd_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [CFG_W-1:0] memDataConfigBus,
  input wire logic lowestAddrInput,
  input wire logic [LOW_W-1:0] lowAddrGroup,
  input wire logic [MID_W-1:0] midAddrGroup,
  input wire logic addrIn17,
  input wire logic addrIn18,
  input wire logic addrIn19,
  input wire logic addrIn20,
  input wire logic spaceSelect,
  output logic [MODE_W-1:0] busMode,
  output logic modeValid,
  output logic [ADDR_W-1:0] byteAddr,
  output logic lowerByteStrobeN,
  output logic cardIoWriteN,
  output logic cardIoReadN,
  output logic cardRegSelectN,
  output logic bufferSelect,
  output logic registerSelect,
  output logic [1:0] bigEndHighBits
);

  logic cardMode;
  logic bigMode;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-1:0] cardAddr_reg;

  hapd_mode_latch u_mode (
    .clock(clock),
    .srst(srst),
    .memDataConfigBus(memDataConfigBus),
    .busMode(busMode),
    .modeValid(modeValid)
  );

  function automatic logic isCard(input logic [MODE_W-1:0] m);
    return (m == HAPD_MODE_CARDCMP);
  endfunction : isCard

  assign cardMode = (busMode == HAPD_MODE_CARDCMP);
  assign bigMode = (busMode == HAPD_MODE_BIGEND);

  // The card bus mode ties pins like the generic bus; only the companion mode uses commands.
  always_comb begin
    addr_next = ADDR_RESET;
    case (busMode)
      HAPD_MODE_CARDCMP: begin
        addr_next = cardAddr_reg;
      end
      default: begin
        // Big-endian host bits count down from 31, so every pin still keeps its own index.
        addr_next[12:1] = lowAddrGroup;
        addr_next[16:13] = midAddrGroup;
        addr_next[20:17] = {addrIn20, addrIn19, addrIn18, addrIn17};
        if (busMode inside {HAPD_MODE_SINGLE32, HAPD_MODE_ISA, HAPD_MODE_BIGEND}) begin
          addr_next[0] = lowestAddrInput;
        end else begin
          addr_next[0] = 1'b0;
        end
      end
    endcase
  end

  // The companion bus multiplexes address onto the pins; latch it while the enable is high.
  always_ff @(posedge clock) begin
    if (srst) begin
      cardAddr_reg <= ADDR_RESET;
    end else begin
      if (cardMode && addrIn20) begin
        cardAddr_reg <= {4'h0, 4'h0, lowAddrGroup, lowestAddrInput};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      byteAddr <= ADDR_RESET;
    end else begin
      byteAddr <= addr_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lowerByteStrobeN <= 1'b1;
      cardIoWriteN <= 1'b1;
      cardIoReadN <= 1'b1;
      cardRegSelectN <= 1'b1;
    end else begin
      lowerByteStrobeN <= (busMode == HAPD_MODE_SPLIT16) ? lowestAddrInput : 1'b1;
      cardIoWriteN <= cardMode ? addrIn17 : 1'b1;
      cardIoReadN <= cardMode ? addrIn18 : 1'b1;
      cardRegSelectN <= cardMode ? addrIn19 : 1'b1;
    end
  end

  // Space select is meaningless on the companion bus, so it routes nowhere there.
  always_ff @(posedge clock) begin
    if (srst) begin
      bufferSelect <= 1'b0;
      registerSelect <= 1'b0;
      bigEndHighBits <= 2'h0;
    end else begin
      bufferSelect <= !isCard(busMode) && spaceSelect;
      registerSelect <= !isCard(busMode) && !spaceSelect;
      bigEndHighBits <= 2'h0;
    end
  end

  // Checks wait for modeValid, since the code changes at the edge that captures it.
  a_strobe_split: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_SPLIT16 && modeValid
    |=> lowerByteStrobeN == $past(lowestAddrInput))
    else $error("Byte strobe not taken from lowest input.");

  a_split_bit0: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_SPLIT16 && modeValid
    |=> byteAddr[0] == 1'b0)
    else $error("Byte strobe leaked into the address.");

  a_strobe_idle: assert property (@(posedge clock) disable iff (srst)
    busMode != HAPD_MODE_SPLIT16 && modeValid
    |=> lowerByteStrobeN)
    else $error("Byte strobe active outside split mode.");

  a_low_ignored: assert property (@(posedge clock) disable iff (srst)
    (busMode == HAPD_MODE_GENERIC || busMode == HAPD_MODE_WESTYLE) && modeValid
    |=> byteAddr[0] == 1'b0)
    else $error("Tied lowest input reached the address.");

  a_cardbus_ignored: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_CARDBUS && modeValid
    |=> byteAddr[0] == 1'b0)
    else $error("Tied lowest input reached the card bus address.");

  a_bit0_used: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_ISA && modeValid
    |=> byteAddr[0] == $past(lowestAddrInput))
    else $error("Bit zero not taken from lowest input.");

  a_bit0_single: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_SINGLE32 && modeValid
    |=> byteAddr[0] == $past(lowestAddrInput))
    else $error("Bit zero not taken in single-strobe mode.");

  a_big_reverse: assert property (@(posedge clock) disable iff (srst)
    bigMode && modeValid
    |=> byteAddr[1] == $past(lowAddrGroup[0]) && byteAddr[20] == $past(addrIn20))
    else $error("Big-endian numbering wrong.");

  a_big_bit0: assert property (@(posedge clock) disable iff (srst)
    bigMode && modeValid
    |=> byteAddr[0] == $past(lowestAddrInput))
    else $error("Big-endian bit zero wrong.");

  a_big_low: assert property (@(posedge clock) disable iff (srst)
    bigMode && modeValid
    |=> byteAddr[12:1] == $past(lowAddrGroup))
    else $error("Big-endian twelve-bit group wrong.");

  a_big_mid: assert property (@(posedge clock) disable iff (srst)
    bigMode && modeValid
    |=> byteAddr[16:13] == $past(midAddrGroup))
    else $error("Big-endian four-bit group wrong.");

  a_big_upper: assert property (@(posedge clock) disable iff (srst)
    bigMode && modeValid
    |=> byteAddr[17] == $past(addrIn17) && byteAddr[19] == $past(addrIn19))
    else $error("Big-endian upper inputs wrong.");

  a_low_group: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_SINGLE32 && modeValid
    |=> byteAddr[12:1] == $past(lowAddrGroup))
    else $error("Twelve-bit group misplaced.");

  a_low_direct: assert property (@(posedge clock) disable iff (srst)
    !cardMode && modeValid
    |=> byteAddr[12:1] == $past(lowAddrGroup))
    else $error("Twelve-bit group not taken directly.");

  a_mid_group: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_ISA && modeValid
    |=> byteAddr[16:13] == $past(midAddrGroup))
    else $error("Four-bit group misplaced.");

  a_mid_direct: assert property (@(posedge clock) disable iff (srst)
    !cardMode && modeValid
    |=> byteAddr[16:13] == $past(midAddrGroup))
    else $error("Four-bit group not taken directly.");

  a_card_upper_zero: assert property (@(posedge clock) disable iff (srst)
    cardMode && modeValid
    |=> byteAddr[20:13] == 8'h00)
    else $error("Tied card pins reached the address.");

  a_card_cmds: assert property (@(posedge clock) disable iff (srst)
    cardMode && modeValid |=> cardIoWriteN == $past(addrIn17)
    && cardIoReadN == $past(addrIn18) && cardRegSelectN == $past(addrIn19))
    else $error("Card commands not decoded.");

  a_io_write: assert property (@(posedge clock) disable iff (srst)
    cardMode && modeValid
    |=> cardIoWriteN == $past(addrIn17))
    else $error("IO write command not decoded.");

  a_cmd_idle: assert property (@(posedge clock) disable iff (srst)
    !cardMode && modeValid
    |=> cardIoReadN && cardIoWriteN && cardRegSelectN)
    else $error("Card command active outside companion mode.");

  a_io_read: assert property (@(posedge clock) disable iff (srst)
    cardMode && modeValid
    |=> cardIoReadN == $past(addrIn18))
    else $error("IO read command not decoded.");

  a_reg_select: assert property (@(posedge clock) disable iff (srst)
    cardMode && modeValid
    |=> cardRegSelectN == $past(addrIn19))
    else $error("Card register select not decoded.");

  sequence s_ale_capture;
    cardMode && addrIn20 ##1 cardMode && !addrIn20;
  endsequence

  sequence s_ale_held;
    cardMode && addrIn20 ##1 cardMode && addrIn20;
  endsequence

  sequence s_ale_idle;
    cardMode && !addrIn20 ##1 cardMode && !addrIn20;
  endsequence

  a_ale_latch: assert property (@(posedge clock) disable iff (srst)
    s_ale_capture |=> byteAddr[12:1] == $past(lowAddrGroup, 2))
    else $error("Latched card address not presented.");

  a_ale_follow: assert property (@(posedge clock) disable iff (srst)
    s_ale_held |=> byteAddr[12:1] == $past(lowAddrGroup, 2))
    else $error("Card address not tracked while enable is high.");

  a_card_bit0: assert property (@(posedge clock) disable iff (srst)
    s_ale_capture |=> byteAddr[0] == $past(lowestAddrInput, 2))
    else $error("Card bit zero not latched.");

  // A user must hold the enable low between accesses, or the address follows the pins.
  a_card_hold: assert property (@(posedge clock) disable iff (srst)
    s_ale_idle |=> $stable(byteAddr))
    else $error("Card address moved while enable was low.");

  a_upper_isa: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_ISA && modeValid
    |=> byteAddr[20] == $past(addrIn20))
    else $error("Input twenty not used as bit twenty.");

  a_upper_bits: assert property (@(posedge clock) disable iff (srst)
    busMode == HAPD_MODE_GENERIC && modeValid
    |=> byteAddr[20:17] == $past({addrIn20, addrIn19, addrIn18, addrIn17}))
    else $error("Upper address bits misplaced.");

  a_upper_direct: assert property (@(posedge clock) disable iff (srst)
    !cardMode && modeValid
    |=> byteAddr[20:17] == $past({addrIn20, addrIn19, addrIn18, addrIn17}))
    else $error("Upper inputs not taken directly.");

  a_space_sel: assert property (@(posedge clock) disable iff (srst)
    !isCard(busMode) && modeValid |=> bufferSelect == $past(spaceSelect)
    && registerSelect == !$past(spaceSelect))
    else $error("Space select routed wrongly.");

  a_space_card: assert property (@(posedge clock) disable iff (srst)
    cardMode && modeValid
    |=> !bufferSelect && !registerSelect)
    else $error("Space select routed on the companion bus.");

  a_space_onehot: assert property (@(posedge clock) disable iff (srst)
    !isCard(busMode) && modeValid
    |=> bufferSelect != registerSelect)
    else $error("Both or neither space selected.");

  a_mode_capture: assert property (@(posedge clock) disable iff (srst)
    modeValid && !$past(modeValid)
    |-> busMode == $past(memDataConfigBus[MODE_LSB +: MODE_W]))
    else $error("Bus mode not taken from the configuration bus.");

  a_high_zero: assert property (@(posedge clock) disable iff (srst)
    modeValid
    |=> bigEndHighBits == 2'h0)
    else $error("Undecoded high bits set.");

endmodule : hapd_addr_decode
`default_nettype wire

// >>> rtl/hapd_mode_latch.sv
`timescale 1ns/1ps
`default_nettype none
module hapd_mode_latch
  import hapd_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [CFG_W-1:0] memDataConfigBus,
  output logic [MODE_W-1:0] busMode,
  output logic modeValid
);

  hapd_state_e state_reg;

  // Mode is caught once at reset release so that later traffic on the data bus cannot alter it.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= HAPD_ST_RESET;
    end else begin
      case (state_reg)
        HAPD_ST_RESET: state_reg <= HAPD_ST_SAMPLE;
        HAPD_ST_SAMPLE: state_reg <= HAPD_ST_RUN;
        HAPD_ST_RUN: state_reg <= HAPD_ST_RUN;
        default: state_reg <= HAPD_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      busMode <= '0;
    end else if (state_reg == HAPD_ST_SAMPLE) begin
      busMode <= memDataConfigBus[MODE_LSB +: MODE_W];
    end
  end

  assign modeValid = (state_reg == HAPD_ST_RUN);

  a_mode_held: assert property (@(posedge clock) disable iff (srst)
    modeValid && $past(modeValid) |-> $stable(busMode))
    else $error("Bus mode changed after capture.");

endmodule : hapd_mode_latch
`default_nettype wire

// >>> rtl/hapd_pkg.sv
package hapd_pkg;

  // Bus mode code taken from the configuration bus at reset.
  localparam int MODE_W = 4;
  typedef enum logic [MODE_W-1:0] {
    HAPD_MODE_GENERIC  = 4'h0,
    HAPD_MODE_WESTYLE  = 4'h1,
    HAPD_MODE_SPLIT16  = 4'h2,
    HAPD_MODE_SINGLE32 = 4'h3,
    HAPD_MODE_ISA      = 4'h4,
    HAPD_MODE_CARDCMP  = 4'h5,
    HAPD_MODE_BIGEND   = 4'h6,
    HAPD_MODE_CARDBUS  = 4'h7
  } hapd_mode_e;

  localparam int CFG_W = 16;
  localparam int MODE_LSB = 0;
  localparam int ADDR_W = 21;
  localparam int LOW_W = 12;
  localparam int MID_W = 4;
  localparam int CARD_CMP_VARIANTS = 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h00_0000;

  typedef enum logic [2:0] {
    HAPD_ST_RESET = 3'b001,
    HAPD_ST_SAMPLE = 3'b010,
    HAPD_ST_RUN = 3'b100
  } hapd_state_e;

endpackage : hapd_pkg

// >>> verif/hapd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hapd_host_model
  import hapd_pkg::*;
(
  input wire logic [MODE_W-1:0] mode,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [3:0] reqAux,
  input wire logic reqSpace,
  output logic lowestAddrInput,
  output logic [LOW_W-1:0] lowAddrGroup,
  output logic [MID_W-1:0] midAddrGroup,
  output logic addrIn17,
  output logic addrIn18,
  output logic addrIn19,
  output logic addrIn20,
  output logic spaceSelect
);
  logic card;
  logic tied;
  assign card = (mode == HAPD_MODE_CARDCMP);
  assign tied = mode inside {HAPD_MODE_GENERIC, HAPD_MODE_WESTYLE, HAPD_MODE_CARDBUS};
  // A tied pin sits high so a decoder that wrongly uses it shows a set bit zero.
  assign lowestAddrInput = tied ? 1'b1 :
    (mode == HAPD_MODE_SPLIT16) ? reqAux[0] : reqAddr[0];
  assign lowAddrGroup = reqAddr[12:1];
  assign midAddrGroup = card ? 4'hf : reqAddr[16:13];
  assign addrIn17 = card ? reqAux[0] : reqAddr[17];
  assign addrIn18 = card ? reqAux[1] : reqAddr[18];
  assign addrIn19 = card ? reqAux[2] : reqAddr[19];
  // Outside companion mode the request is held for the whole access, so input twenty arrives already latched; there it carries the enable from reqAux[3].
  assign addrIn20 = card ? reqAux[3] : reqAddr[20];
  assign spaceSelect = card ? 1'b1 : reqSpace;
endmodule : hapd_host_model
`default_nettype wire

// >>> verif/test_hapd_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_hapd_addr_decode
  import hapd_pkg::*;
;
  logic clock, srst, reqSpace, lowIn, a17, a18, a19, a20, space, mValid, lbsN, wrN, rdN, regN;
  logic bufSel, regSel;
  logic [1:0] beHigh;
  logic [CFG_W-1:0] cfg;
  logic [MODE_W-1:0] mode, busMode;
  logic [ADDR_W-1:0] reqAddr, byteAddr, latched;
  logic [3:0] reqAux;
  logic [LOW_W-1:0] lowGrp;
  logic [MID_W-1:0] midGrp;
  integer seed = 32'h0000_4727;
  int n_mismatch = 0;
  int checked = 0;
  logic [MODE_W-1:0] modes [8] = '{HAPD_MODE_GENERIC, HAPD_MODE_WESTYLE, HAPD_MODE_SPLIT16,
    HAPD_MODE_SINGLE32, HAPD_MODE_ISA, HAPD_MODE_BIGEND, HAPD_MODE_CARDBUS, 4'hc};
  hapd_host_model hapd_host_model_inst (.mode(mode), .reqAddr(reqAddr), .reqAux(reqAux),
    .reqSpace(reqSpace), .lowestAddrInput(lowIn), .lowAddrGroup(lowGrp),
    .midAddrGroup(midGrp), .addrIn17(a17), .addrIn18(a18), .addrIn19(a19),
    .addrIn20(a20), .spaceSelect(space));
  hapd_addr_decode hapd_addr_decode_inst (.clock(clock), .srst(srst),
    .memDataConfigBus(cfg), .lowestAddrInput(lowIn), .lowAddrGroup(lowGrp),
    .midAddrGroup(midGrp), .addrIn17(a17), .addrIn18(a18), .addrIn19(a19),
    .addrIn20(a20), .spaceSelect(space), .busMode(busMode), .modeValid(mValid),
    .byteAddr(byteAddr), .lowerByteStrobeN(lbsN), .cardIoWriteN(wrN), .cardIoReadN(rdN),
    .cardRegSelectN(regN), .bufferSelect(bufSel), .registerSelect(regSel),
    .bigEndHighBits(beHigh));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string name, input logic [ADDR_W-1:0] exp,
    input logic [ADDR_W-1:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Big-endian numbering still lands every pin on the byte address bit of the same index.
  function automatic logic [ADDR_W-1:0] expAddr(input logic [MODE_W-1:0] m,
    input logic [ADDR_W-1:0] a);
    if (m inside {HAPD_MODE_SINGLE32, HAPD_MODE_ISA, HAPD_MODE_BIGEND}) return a;
    return {a[ADDR_W-1:1], 1'b0};
  endfunction : expAddr
  task automatic restart(input logic [MODE_W-1:0] m);
    @(posedge clock);
    srst <= 1'b1;
    mode <= m;
    cfg <= {12'($random(seed)), m};
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    #1 chk("reset addr", 21'h00_0000, byteAddr);
    chk("reset strobe", 21'h00_0001, 21'(lbsN));
    repeat (2) @(posedge clock);
    #1 chk("busMode", 21'({1'b1, m}), 21'({mValid, busMode}));
  endtask : restart
  task automatic xfer();
    @(posedge clock);
    reqAddr <= ADDR_W'($random(seed));
    reqAux <= 4'($random(seed));
    reqSpace <= 1'($random(seed));
    @(posedge clock);
    #1 chk("byteAddr", expAddr(mode, reqAddr), byteAddr);
    chk("strobe", 21'(mode == HAPD_MODE_SPLIT16 ? reqAux[0] : 1'b1), 21'(lbsN));
    chk("commands", 21'h00_0007, 21'({wrN, rdN, regN}));
    chk("space", 21'({reqSpace, !reqSpace}), 21'({bufSel, regSel}));
    chk("high bits", 21'h00_0000, 21'(beHigh));
  endtask : xfer
  task complete_run();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    srst = 1'b1;
    cfg = 16'h0000;
    mode = 4'h0;
    reqAddr = 21'h00_0000;
    reqAux = 4'hf;
    reqSpace = 1'b0;
    foreach (modes[i]) begin
      restart(modes[i]);
      repeat (24) xfer();
    end
    restart(HAPD_MODE_CARDCMP);
    repeat (12) begin
      @(posedge clock);
      reqAddr <= ADDR_W'($random(seed));
      reqAux <= 4'hf;
      @(posedge clock);
      latched = {8'h00, reqAddr[12:0]};
      reqAddr <= ADDR_W'($random(seed));
      reqAux <= {1'b0, 3'($random(seed))};
      @(posedge clock);
      #1 chk("card addr", latched, byteAddr);
      chk("io write", 21'(reqAux[0]), 21'(wrN));
      chk("io read", 21'(reqAux[1]), 21'(rdN));
      chk("reg select", 21'(reqAux[2]), 21'(regN));
      chk("card space", 21'h00_0000, 21'({bufSel, regSel}));
    end
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end
endmodule : test_hapd_addr_decode
`default_nettype wire
